// File: bench/flash_dev_model.sv
// Purpose: Behavioural flash device that answers the host controller on its parallel pins.
// Assumes: Host strobes are registered on MCLK, so edges are found by sampling at MCLK.
// Notes: Identification codes are arbitrary values; embedded work is a plain cycle count.
module flash_dev_model #(
	parameter logic [7:0] MFR_CODE = 8'h3c,
	parameter logic [7:0] DEV_CODE = 8'hc3,
	parameter logic [7:0] PROT_MASK = 8'h24,
	parameter int RUN_CYC = 60
) (
	input wire logic MCLK,
	input wire logic CS_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic [18:0] ADDR,
	input wire logic [7:0] HOST_D,
	input wire logic HOST_OE,
	output logic [7:0] BUS,
	output logic OP_RUNNING
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [7:0] keep [int];
	logic [18:0] a_q = 19'h00000;
	logic we_p = 1'b1;
	logic ident = 1'b0;
	logic susp = 1'b0;
	logic [7:0] rd = 8'hff;
	logic [7:0] last = 8'h00;
	logic [7:0] d;
	int step = 0;
	int run = 0;
	int er = -1;
	// A released bus shows the inverse of its last level, so a stale sample cannot pass.
	assign BUS = HOST_OE ? HOST_D : (!CS_N && !OE_N) ? rd : ~last;
	// Outputs change by non-blocking assignment, so the host never races them at the edge.
	always @(posedge MCLK) begin
		last <= BUS;
		if (run > 0 && !susp) begin
			run = run - 1;
			if (run == 0 && er >= 0) begin
				keep.delete();
				foreach (mem[k]) if (er < 8 && k[18:16] != er) keep[k] = mem[k];
				mem = keep;
			end
		end
		// Address latches when the later of strobe or select falls; data when the first of them rises.
		if (we_p && !(WE_N || CS_N)) a_q = ADDR;
		if (!we_p && (WE_N || CS_N) && OE_N) begin
			d = BUS;
			if (run > 0 && !susp) begin
				if (er inside {[0:7]} && d == 8'hb0) susp = 1'b1;
			end else if (susp && d == 8'h30) susp = 1'b0;
			else if (d == 8'hf0 && step != 6) begin
				ident = 1'b0;
				step = 0;
			end else case (step)
				0: step = (a_q[14:0] == 15'h5555 && d == 8'haa) ? 1 : 0;
				1: step = (a_q[14:0] == 15'h2aaa && d == 8'h55) ? 2 : 0;
				2: begin
					step = 0;
					if (a_q[14:0] == 15'h5555 && d == 8'h90) ident = 1'b1;
					if (a_q[14:0] == 15'h5555 && d == 8'ha0) step = 6;
					if (a_q[14:0] == 15'h5555 && d == 8'h80) step = 3;
				end
				3: step = (a_q[14:0] == 15'h5555 && d == 8'haa) ? 4 : 0;
				4: step = (a_q[14:0] == 15'h2aaa && d == 8'h55) ? 5 : 0;
				5: begin
					step = 0;
					if (a_q[14:0] == 15'h5555 && d == 8'h10) begin
						er = 8;
						run = RUN_CYC;
					end
					if (d == 8'h30) begin
						er = a_q[18:16];
						run = RUN_CYC;
					end
				end
				6: begin
					mem[a_q] = d;
					er = -1;
					run = RUN_CYC;
					step = 0;
				end
				default: step = 0;
			endcase
		end
		we_p = WE_N || CS_N;
		// Read data lags the address by one cycle, well inside the host's sampling delay.
		rd <= !ident ? (mem.exists(ADDR) ? mem[ADDR] : 8'hff) :
			ADDR[1:0] == 2'b00 ? MFR_CODE : ADDR[1:0] == 2'b01 ? DEV_CODE :
			ADDR[1:0] == 2'b10 ? {7'h00, PROT_MASK[ADDR[18:16]]} : 8'h00;
		OP_RUNNING <= (run > 0) && !susp;
	end
endmodule

// File: bench/test_flash_cmd_host.sv
// Purpose: Self-checking bench for the flash command host against a device model.
// Assumes: One request at a time, each waited for under a bounded loop.
// Notes: Expected data comes from a bench-side memory model, never from the design.
module test_flash_cmd_host;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MFR = 8'h3c;
	localparam logic [7:0] DEV = 8'hc3;
	localparam logic [7:0] PROT = 8'h24;
	logic MCLK = 1'b0;
	logic RST_B = 1'b0;
	logic REQ_VALID = 1'b0;
	flash_host_pkg::req_t REQ = '0;
	logic REQ_READY, RSP_VALID, BUSY_REFUSED, OP_RUNNING, DATA_PINS_OE;
	logic CHIP_SELECT_N, OUTPUT_GATE_N, WRITE_STROBE_N;
	logic [7:0] RSP_DATA, DATA_PINS_I, DATA_PINS_O, got;
	logic [18:0] ADDR;
	logic [18:0] pa [3];
	logic [7:0] mem_b [int];
	logic ident_b = 1'b0;
	logic refd;
	int err_total = 0;
	int n_compared = 0;
	int seed = 81;
	always #20 MCLK = ~MCLK;
	flash_cmd_host flash_cmd_host_i (.MCLK(MCLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
		.REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
		.BUSY_REFUSED(BUSY_REFUSED), .OP_RUNNING(OP_RUNNING), .CHIP_SELECT_N(CHIP_SELECT_N),
		.OUTPUT_GATE_N(OUTPUT_GATE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .ADDR(ADDR),
		.DATA_PINS_I(DATA_PINS_I), .DATA_PINS_O(DATA_PINS_O), .DATA_PINS_OE(DATA_PINS_OE));
	flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT_MASK(PROT), .RUN_CYC(60))
		flash_dev_model_i (.MCLK(MCLK), .CS_N(CHIP_SELECT_N), .OE_N(OUTPUT_GATE_N),
		.WE_N(WRITE_STROBE_N), .ADDR(ADDR), .HOST_D(DATA_PINS_O), .HOST_OE(DATA_PINS_OE),
		.BUS(DATA_PINS_I), .OP_RUNNING(OP_RUNNING));
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic do_op(input flash_host_pkg::op_t op, input logic [18:0] a,
		input logic [7:0] d, input logic exp_ref);
		int n;
		@(posedge MCLK);
		REQ_VALID <= 1'b1;
		REQ <= '{op: op, addr: a, data: d};
		n = 0;
		do begin @(negedge MCLK); n++; end while (REQ_READY !== 1'b1 && n < 100);
		bound(n, 100);
		@(posedge MCLK);
		REQ_VALID <= 1'b0;
		n = 0;
		do begin @(negedge MCLK); n++; end while (RSP_VALID !== 1'b1 &&
			BUSY_REFUSED !== 1'b1 && n < 200);
		bound(n, 200);
		refd = BUSY_REFUSED;
		got = RSP_DATA;
		check({7'h00, refd}, {7'h00, exp_ref});
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin @(negedge MCLK); n++; end while (OP_RUNNING !== 1'b0 && n < 500);
		bound(n, 500);
		// The controller tracks the running flag through three flops.
		repeat (3) @(posedge MCLK);
	endtask
	function automatic logic [7:0] expv(input logic [18:0] a);
		if (ident_b) return a[1:0] == 2'b00 ? MFR : a[1:0] == 2'b01 ? DEV : 8'h00;
		return mem_b.exists(a) ? mem_b[a] : 8'hff;
	endfunction
	task automatic rd(input logic [18:0] a);
		do_op(flash_host_pkg::OP_READ, a, 8'h00, 1'b0);
		check(got, expv(a));
	endtask
	task automatic erase_b(input int s);
		logic [7:0] k [int];
		foreach (mem_b[i]) if (s < 8 && i[18:16] != s) k[i] = mem_b[i];
		mem_b = k;
	endtask
	initial begin
		logic [18:0] a;
		logic [7:0] d;
		repeat (5) @(posedge MCLK);
		RST_B <= 1'b1;
		for (int i = 0; i < 4; i++) rd(19'($random(seed)));
		$display("test power-up reads done");
		for (int i = 0; i < 3; i++) begin
			pa[i] = 19'($random(seed));
			d = 8'($random(seed));
			do_op(flash_host_pkg::OP_PROGRAM, pa[i], d, 1'b0);
			mem_b[pa[i]] = d;
			repeat (2) @(posedge MCLK);
			do_op(flash_host_pkg::OP_PROGRAM, pa[i] ^ 19'h00001, d, 1'b1);
			wait_idle();
			rd(pa[i]);
		end
		$display("test program done");
		for (int r = 0; r < 2; r++) begin
			do_op(flash_host_pkg::OP_IDENT, 19'($random(seed)), 8'h00, 1'b0);
			ident_b = 1'b1;
			do_op(flash_host_pkg::OP_ID_MFR, 19'($random(seed)), 8'h00, 1'b0);
			check(got, MFR);
			do_op(flash_host_pkg::OP_ID_DEV, 19'($random(seed)), 8'h00, 1'b0);
			check(got, DEV);
			a = 19'($random(seed));
			a[1:0] = 2'b01;
			rd(a);
			for (int s = 0; s < 8; s++) begin
				do_op(flash_host_pkg::OP_PROT_STATUS, {3'(s), 16'h0000}, 8'h00, 1'b0);
				check(got & 8'h01, {7'h00, PROT[s]});
			end
			do_op(r == 0 ? flash_host_pkg::OP_RESET_SHORT : flash_host_pkg::OP_RESET_LONG,
				19'($random(seed)), 8'h00, 1'b0);
			ident_b = 1'b0;
			rd(pa[r]);
		end
		$display("test identification done");
		do_op(flash_host_pkg::OP_SUSPEND, 19'h00000, 8'h00, 1'b1);
		do_op(flash_host_pkg::OP_RESUME, 19'h00000, 8'h00, 1'b1);
		do_op(flash_host_pkg::OP_SECTOR_ERASE, pa[0], 8'h00, 1'b0);
		do_op(flash_host_pkg::OP_SUSPEND, 19'h00000, 8'h00, 1'b0);
		rd(pa[1]);
		do_op(flash_host_pkg::OP_RESUME, 19'h00000, 8'h00, 1'b0);
		erase_b(pa[0][18:16]);
		wait_idle();
		for (int i = 0; i < 3; i++) rd(pa[i]);
		// A finished erase leaves nothing to suspend, so the controller must refuse.
		do_op(flash_host_pkg::OP_SUSPEND, 19'h00000, 8'h00, 1'b1);
		$display("test sector erase done");
		do_op(flash_host_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00, 1'b0);
		do_op(flash_host_pkg::OP_SECTOR_ERASE, pa[1], 8'h00, 1'b1);
		erase_b(8);
		wait_idle();
		for (int i = 0; i < 3; i++) rd(pa[i]);
		$display("test chip erase done");
		close_out();
	end
endmodule

// File: src/flash_bus_cycle.sv
// Purpose: Runs one strobed read or write cycle on the flash pins.
// Assumes: The caller holds start only while ready is high.
// Notes: Writes keep the output gate high and pulse the write strobe inside chip select.
module flash_bus_cycle (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic start,
	input wire flash_host_pkg::cyc_t cyc,
	input wire logic [7:0] din_sync,
	output logic ready,
	output logic done,
	output logic [7:0] rdata,
	output flash_host_pkg::pins_t pins
);
	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} ph_t;
	typedef struct packed {
		ph_t ph;
		logic [3:0] cnt;
		flash_host_pkg::cyc_t c;
		logic done;
		logic [7:0] rdata;
		flash_host_pkg::pins_t pins;
	} st_t;
	st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		unique case (s_q.ph)
			S_IDLE: begin
				s_d.pins.cs_n = 1'b1;
				s_d.pins.oe_n = 1'b1;
				s_d.pins.we_n = 1'b1;
				s_d.pins.den = 1'b0;
				if (start) begin
					s_d.c = cyc;
					s_d.ph = S_SETUP;
					s_d.cnt = flash_host_pkg::SETUP_CYC;
					s_d.pins.addr = cyc.addr;
					s_d.pins.dout = cyc.data;
					s_d.pins.cs_n = 1'b0;
					// A write keeps the gate high so the flash leaves the data pins alone.
					s_d.pins.oe_n = cyc.write;
					s_d.pins.den = cyc.write;
				end
			end
			S_SETUP: begin
				s_d.cnt = s_q.cnt - 4'h1;
				if (s_q.cnt == 4'h1) begin
					s_d.ph = S_PULSE;
					// Address is latched by the flash at this falling edge.
					// The strobe falls and rises inside select, so either latch form sees it.
					s_d.pins.we_n = !s_q.c.write;
					s_d.cnt = s_q.c.write ? flash_host_pkg::PULSE_CYC
						: flash_host_pkg::SAMPLE_CYC;
				end
			end
			S_PULSE: begin
				s_d.cnt = s_q.cnt - 4'h1;
				if (s_q.cnt == 4'h1) begin
					s_d.ph = S_HOLD;
					s_d.cnt = flash_host_pkg::HOLD_CYC;
					// Data is latched at the rising edge; read data is sampled here.
					s_d.pins.we_n = 1'b1;
					s_d.pins.oe_n = 1'b1;
					if (!s_q.c.write) begin
						s_d.rdata = din_sync;
					end
				end
			end
			S_HOLD: begin
				s_d.cnt = s_q.cnt - 4'h1;
				if (s_q.cnt == 4'h1) begin
					s_d.ph = S_IDLE;
					s_d.pins.cs_n = 1'b1;
					s_d.pins.den = 1'b0;
					s_d.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			s_q <= '{ph: S_IDLE, cnt: 4'h0, c: '0, done: 1'b0, rdata: 8'h00,
				pins: '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: 8'h00, den: 1'b0}};
		end else begin
			s_q <= s_d;
		end
	end

	assign ready = (s_q.ph == S_IDLE);
	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign pins = s_q.pins;

	strobe_in_cs_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		!pins.we_n |-> !pins.cs_n && pins.oe_n) else $error("write strobe outside select");
	gate_no_drive_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		!pins.oe_n |-> !pins.den) else $error("host drives while gate low");
endmodule

// File: src/flash_cmd_host.sv
// Purpose: Host controller that issues flash command sequences over the parallel pins.
// Assumes: One request at a time; the flash keeps its own command decoder and embedded engine.
// Notes: High voltage identification by pin is not generated; codes are read by command.
// Operation
// - Pin identification needs high voltage on addr_bit9, addr_bit1 and addr_bit6 low.
// - Write: select low, gate high, strobe pulsed; address at fall, data at rise.
// - Flash also accepts select-pulsed writes with the strobe held low.
// - Reset: F0h anywhere, or AAh/5555h, 55h/2AAAh, F0h/5555h.
// - Identification command: unlock pair then 90h to 5555h.
// - Program: unlock pair, A0h to 5555h, then value to target address.
// - Erase: unlock, 80h, unlock, then 10h to 5555h or 30h to sector.
// - B0h suspends a sector erase; 30h resumes while suspended.
// - Identification mode or a timeout flag is left only by a reset command; the host also leaves M_IDENT (for M_BULK) once a sector erase sequence is issued.
module flash_cmd_host (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire flash_host_pkg::req_t REQ,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic BUSY_REFUSED,
	input wire logic OP_RUNNING,
	output logic CHIP_SELECT_N,
	output logic OUTPUT_GATE_N,
	output logic WRITE_STROBE_N,
	output logic [18:0] ADDR,
	input wire logic [7:0] DATA_PINS_I,
	output logic [7:0] DATA_PINS_O,
	output logic DATA_PINS_OE
);
	typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} hs_t;
	typedef enum logic [1:0] {M_READ, M_IDENT, M_BULK, M_SUSP} fm_t;
	typedef struct packed {
		hs_t hs;
		fm_t fmode;
		flash_host_pkg::req_t r;
		logic [2:0] step;
		logic [2:0] last;
		logic rsp;
		logic [7:0] rdat;
		logic refused;
		logic [7:0] din1;
		logic [7:0] din2;
		logic [2:0] run_sync;
	} st_t;
	st_t s_q, s_d;
	flash_host_pkg::cyc_t cyc;
	flash_host_pkg::pins_t pins;
	logic bc_ready, bc_done, bc_start;
	logic [7:0] bc_rdata;
	logic is_bulk;

	// Builds each bus cycle of a sequence; unlock addresses carry zeros in bits 15 to 18.
	function automatic flash_host_pkg::cyc_t seq_cycle(flash_host_pkg::req_t r, logic [2:0] k);
		flash_host_pkg::cyc_t c;
		logic [18:0] a [6];
		logic [7:0] d [6];
		c = '0;
		a[0] = flash_host_pkg::UNLOCK_A1;
		d[0] = flash_host_pkg::UNLOCK_D1;
		a[1] = flash_host_pkg::UNLOCK_A2;
		d[1] = flash_host_pkg::UNLOCK_D2;
		a[2] = flash_host_pkg::UNLOCK_A1;
		d[2] = flash_host_pkg::CMD_ERASE;
		a[3] = flash_host_pkg::UNLOCK_A1;
		d[3] = flash_host_pkg::UNLOCK_D1;
		a[4] = flash_host_pkg::UNLOCK_A2;
		d[4] = flash_host_pkg::UNLOCK_D2;
		a[5] = flash_host_pkg::UNLOCK_A1;
		d[5] = flash_host_pkg::CMD_CHIP;
		c.write = 1'b1;
		c.addr = a[k];
		c.data = d[k];
		unique case (r.op)
			flash_host_pkg::OP_READ, flash_host_pkg::OP_ID_MFR, flash_host_pkg::OP_ID_DEV,
			flash_host_pkg::OP_PROT_STATUS: begin
				c.write = 1'b0;
				c.addr = r.addr;
				c.data = 8'h00;
				// Code reads keep address bits 1 and 6 low, as selection by pin would need.
				if (r.op == flash_host_pkg::OP_ID_MFR) begin
					c.addr = flash_host_pkg::ID_MFR_ADDR;
				end
				if (r.op == flash_host_pkg::OP_ID_DEV) begin
					c.addr = flash_host_pkg::ID_DEV_ADDR;
				end
				if (r.op == flash_host_pkg::OP_PROT_STATUS) begin
					// Sector bits come from the caller, bit 0 low, bit 1 high.
					c.addr = {r.addr[18:flash_host_pkg::SECTOR_LSB], 14'h0000, 2'h2};
				end
			end
			flash_host_pkg::OP_RESET_SHORT, flash_host_pkg::OP_SUSPEND,
			flash_host_pkg::OP_RESUME: begin
				c.addr = r.addr;
				c.data = (r.op == flash_host_pkg::OP_RESET_SHORT) ? flash_host_pkg::CMD_RESET
					: (r.op == flash_host_pkg::OP_SUSPEND) ? flash_host_pkg::CMD_SUSPEND
					: flash_host_pkg::CMD_RESUME;
			end
			flash_host_pkg::OP_RESET_LONG, flash_host_pkg::OP_IDENT,
			flash_host_pkg::OP_PROGRAM: begin
				if (k == 3'h2) begin
					c.data = (r.op == flash_host_pkg::OP_RESET_LONG) ? flash_host_pkg::CMD_RESET
						: (r.op == flash_host_pkg::OP_IDENT) ? flash_host_pkg::CMD_IDENT
						: flash_host_pkg::CMD_PROG;
				end
				if (k == 3'h3) begin
					c.addr = r.addr;
					c.data = r.data;
				end
			end
			flash_host_pkg::OP_CHIP_ERASE: begin
			end
			flash_host_pkg::OP_SECTOR_ERASE: begin
				if (k == 3'h5) begin
					c.addr = {r.addr[18:flash_host_pkg::SECTOR_LSB], 16'h0000};
					c.data = flash_host_pkg::CMD_SECTOR;
				end
			end
			default: begin
			end
		endcase
		return c;
	endfunction

	function automatic logic [2:0] seq_last(flash_host_pkg::op_t op);
		unique case (op)
			flash_host_pkg::OP_RESET_LONG, flash_host_pkg::OP_IDENT: return 3'h2;
			flash_host_pkg::OP_PROGRAM: return 3'h3;
			flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE:
				return flash_host_pkg::MAX_STEP;
			default: return 3'h0;
		endcase
	endfunction

	assign is_bulk = (REQ.op == flash_host_pkg::OP_PROGRAM)
		|| (REQ.op == flash_host_pkg::OP_CHIP_ERASE)
		|| (REQ.op == flash_host_pkg::OP_SECTOR_ERASE);

	always_comb begin
		s_d = s_q;
		s_d.rsp = 1'b0;
		s_d.refused = 1'b0;
		s_d.din1 = DATA_PINS_I;
		s_d.din2 = s_q.din1;
		s_d.run_sync = {s_q.run_sync[1:0], OP_RUNNING};
		// The engine ends on its own, so a finished sector erase puts the tracked mode back to reading.
		// A suspend also drops the flag, but by then the mode is already marked suspended.
		if (s_q.run_sync[2] && !s_q.run_sync[1] && s_q.fmode == M_BULK) begin
			s_d.fmode = M_READ;
		end
		unique case (s_q.hs)
			H_IDLE: begin
				if (REQ_VALID) begin
					// Program or erase while one runs would be ignored, so it is refused here.
					if (is_bulk && s_q.run_sync[1]) begin
						s_d.refused = 1'b1;
					end else if ((REQ.op == flash_host_pkg::OP_SUSPEND
						&& s_q.fmode != M_BULK)
						|| (REQ.op == flash_host_pkg::OP_RESUME
						&& s_q.fmode != M_SUSP)) begin
						s_d.refused = 1'b1;
					end else begin
						s_d.r = REQ;
						s_d.step = 3'h0;
						s_d.last = seq_last(REQ.op);
						s_d.hs = H_ISSUE;
					end
				end
			end
			H_ISSUE: begin
				if (bc_ready) begin
					s_d.hs = H_WAIT;
				end
			end
			H_WAIT: begin
				if (bc_done) begin
					if (s_q.step == s_q.last) begin
						s_d.hs = H_IDLE;
						s_d.rsp = 1'b1;
						s_d.rdat = bc_rdata;
						unique case (s_q.r.op)
							flash_host_pkg::OP_RESET_SHORT, flash_host_pkg::OP_RESET_LONG:
								s_d.fmode = M_READ;
							flash_host_pkg::OP_IDENT: s_d.fmode = M_IDENT;
							flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_RESUME:
								s_d.fmode = M_BULK;
							flash_host_pkg::OP_SUSPEND: s_d.fmode = M_SUSP;
							default: begin
							end
						endcase
					end else begin
						s_d.step = s_q.step + 3'h1;
						s_d.hs = H_ISSUE;
					end
				end
			end
			default: s_d.hs = H_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			// The flash powers up reading its array, so the host starts there too.
			s_q <= '{hs: H_IDLE, fmode: M_READ, r: '0, step: 3'h0, last: 3'h0,
				rsp: 1'b0, rdat: 8'h00, refused: 1'b0, din1: 8'h00, din2: 8'h00, run_sync: 3'h0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cyc = seq_cycle(s_q.r, s_q.step);
	assign bc_start = (s_q.hs == H_ISSUE) && bc_ready;

	flash_bus_cycle u_cycle (
		.MCLK(MCLK),
		.RST_B(RST_B),
		.start(bc_start),
		.cyc(cyc),
		.din_sync(s_q.din2),
		.ready(bc_ready),
		.done(bc_done),
		.rdata(bc_rdata),
		.pins(pins)
	);

	assign REQ_READY = (s_q.hs == H_IDLE);
	assign RSP_VALID = s_q.rsp;
	assign RSP_DATA = s_q.rdat;
	assign BUSY_REFUSED = s_q.refused;
	assign CHIP_SELECT_N = pins.cs_n;
	assign OUTPUT_GATE_N = pins.oe_n;
	assign WRITE_STROBE_N = pins.we_n;
	assign ADDR = pins.addr;
	assign DATA_PINS_O = pins.dout;
	assign DATA_PINS_OE = pins.den;

	bulk_refused_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		REQ_VALID && REQ_READY && is_bulk && s_q.run_sync[1] |=> BUSY_REFUSED && REQ_READY)
		else $error("bulk request not refused while running");
	unlock_first_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_start && s_q.step == 3'h0 && s_q.last != 3'h0 |->
		cyc.addr == flash_host_pkg::UNLOCK_A1 && cyc.data == flash_host_pkg::UNLOCK_D1)
		else $error("sequence does not open with unlock");
	unlock_high_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_start && s_q.step < s_q.last |-> cyc.addr[18:15] == 4'h0)
		else $error("unlock cycle carries high address bits");
	prog_final_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_start && s_q.r.op == flash_host_pkg::OP_PROGRAM && s_q.step == 3'h3 |->
		cyc.addr == s_q.r.addr && cyc.data == s_q.r.data)
		else $error("program final cycle wrong");
	sector_final_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_start && s_q.r.op == flash_host_pkg::OP_SECTOR_ERASE && s_q.step == 3'h5 |->
		cyc.data == flash_host_pkg::CMD_SECTOR && cyc.addr[18:16] == s_q.r.addr[18:16])
		else $error("sector erase final cycle wrong");
	ident_mode_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_done && s_q.step == s_q.last && s_q.r.op == flash_host_pkg::OP_IDENT |=>
		s_q.fmode == M_IDENT) else $error("ident mode not tracked");
	resume_refused_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		REQ_VALID && REQ_READY && REQ.op == flash_host_pkg::OP_RESUME
		&& s_q.fmode != M_SUSP |=> BUSY_REFUSED)
		else $error("resume outside suspend");
	prot_addr_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		bc_start && s_q.r.op == flash_host_pkg::OP_PROT_STATUS |->
		cyc.addr[1:0] == 2'h2 && !cyc.write) else $error("protection read address");
	rsp_after_req_a: assert property (@(posedge MCLK) disable iff (!RST_B)
		RSP_VALID |-> $past(s_q.hs) == H_WAIT) else $error("response without work");
	program_cov: cover property (@(posedge MCLK) disable iff (!RST_B)
		RSP_VALID && s_q.r.op == flash_host_pkg::OP_PROGRAM);
	sector_cov: cover property (@(posedge MCLK) disable iff (!RST_B)
		RSP_VALID && s_q.r.op == flash_host_pkg::OP_SECTOR_ERASE);
	ident_cov: cover property (@(posedge MCLK) disable iff (!RST_B)
		RSP_VALID && s_q.r.op == flash_host_pkg::OP_ID_DEV);
	refuse_cov: cover property (@(posedge MCLK) disable iff (!RST_B) BUSY_REFUSED);
endmodule

// File: src/flash_host_pkg.sv
// Purpose: Shared constants and carriers for the flash command host controller.
// Assumes: Byte-wide asynchronous flash with 19 address bits, driven from a 25 MHz clock.
// Notes: Strobe timing counts are derived from nanosecond figures at the clock rate.
package flash_host_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CLK_NS = 40;
	// Strobe phase lengths; least times round up to whole cycles.
	localparam int SETUP_NS = 40;
	localparam int PULSE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int SAMPLE_NS = 160;
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SAMPLE_CYC = 4'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [18:0] UNLOCK_A1 = 19'h05555;
	localparam logic [18:0] UNLOCK_A2 = 19'h02aaa;
	localparam logic [7:0] UNLOCK_D1 = 8'haa;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [18:0] ID_MFR_ADDR = 19'h00000;
	localparam logic [18:0] ID_DEV_ADDR = 19'h00001;
	localparam logic [18:0] ID_PROT_ADDR = 19'h00002;
	localparam int SECTOR_LSB = 16;
	localparam logic [2:0] MAX_STEP = 3'h5;
	// Operation codes accepted on the user side.
	typedef enum logic [3:0] {
		OP_READ, OP_RESET_SHORT, OP_RESET_LONG, OP_IDENT, OP_PROGRAM,
		OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME,
		OP_ID_MFR, OP_ID_DEV, OP_PROT_STATUS
	} op_t;
	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} req_t;
	// One bus cycle toward the flash.
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cyc_t;
	typedef struct packed {
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic den;
	} pins_t;
endpackage
